// [hw/uart_irq_regs.vh]
`ifndef UART_IRQ_REGS_VH
`define UART_IRQ_REGS_VH

// Register byte offsets
`define OFS_DATA_PORT     8'h00
`define OFS_IRQ_ENABLE    8'h04
`define OFS_IRQ_STATUS    8'h08
`define OFS_FIFO_STATUS   8'h0c
`define OFS_MODEM_STATUS  8'h10
`define OFS_FIFO_CTRL     8'h14
`define OFS_TIMEOUT       8'h20

// Enable bit positions
`define EN_RDA            0
`define EN_THRE           1
`define EN_RLS            2
`define EN_MODEM          3
`define EN_TOUT           4
`define EN_BUFERR         8

// Status flag positions; indicators sit 8 bits above each flag
`define ST_RDA            0
`define ST_THRE           1
`define ST_RLS            2
`define ST_MODEM          3
`define ST_TOUT           4
`define ST_BUFERR         5
`define ST_IND_SHIFT      8

// FIFO status bit positions
`define FS_RX_OVF         0
`define FS_ADDR_DET       3
`define FS_PARITY         4
`define FS_FRAMING        5
`define FS_BREAK          6
`define FS_TX_OVF         24

// Modem status bit positions
`define MS_CTS_DET        0
`define MS_CTS_STATE      4

// FIFO control fields
`define FC_TRIG_LSB       4
`define FC_TRIG_MSB       7
`define FC_RS485          8

// Time-out compare field
`define TO_CMP_MSB        7

// Reset values
`define RST_IRQ_ENABLE    9'h000
`define RST_TRIG_LEVEL    4'h1
`define RST_TIMEOUT_CMP   8'h00

`endif

// [hw/uart_irq_status.v]
// Notes on behaviour
// R1 - Buffer error set by either FIFO overflow
// R2 - Buffer error interrupt when flag and enable
// R3 - Buffer error clears once both overflows cleared
// R4 - Time-out set: data held, idle, counter matches
// R5 - Time-out clears on data read while receiving
// R6 - Time-out interrupt when flag and enable
// R7 - Modem flag set on clear-to-send change
// R8 - Modem interrupt when flag and enable
// R9 - Modem flag clears with change-detect write-one
// R10 - Line status set by break, framing, parity
// R11 - RS-485 address byte sets line status too
// R12 - Normal mode: clears when three errors clear
// R13 - RS-485: clears when four flags clear
// R14 - Line status interrupt when flag and enable
// R15 - Holding empty set when last word shifts
// R16 - Holding empty clears on data write
// R17 - Holding empty interrupt when flag and enable
// R18 - Data available set when count equals trigger
// R19 - Data available clears when count below trigger
// R20 - Data available interrupt when flag and enable
// R21 - Counter restarts on new word, counts baud
// R22 - Indicator equals flag AND enable per source
// R23 - All source flags clocked, cleared by reset

`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_regs.vh"

module uart_irq_status (
  input  wire        ref_clk,
  input  wire        rst_n,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Receive side status from the UART datapath
  input  wire [4:0]  rx_fifo_count,
  input  wire [7:0]  rx_fifo_data,
  input  wire        rx_fifo_push,
  input  wire        rx_active,
  input  wire        rx_overflow_event,
  input  wire        parity_error_event,
  input  wire        framing_error_event,
  input  wire        break_event,
  input  wire        address_byte_event,
  input  wire        baud_tick,
  // Transmit side status
  input  wire        tx_overflow_event,
  input  wire        tx_shift_load,
  input  wire        tx_fifo_empty,
  // Modem pin
  input  wire        clear_to_send_input_n,
  // Data port strobes toward the FIFOs
  output wire        rx_read_strobe,
  output wire        tx_write_strobe,
  output reg  [7:0]  tx_write_data,
  // Per-source interrupt lines
  output wire        rda_irq,
  output wire        thre_irq,
  output wire        rls_irq,
  output wire        modem_irq,
  output wire        timeout_irq,
  output wire        buffer_error_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [8:0] irq_enable;
  reg  [3:0] rx_fifo_trigger_level;
  reg        rs485_mode;
  reg  [7:0] timeout_compare_value;
  reg  [7:0] timeout_count;

  reg        rx_fifo_overflow_flag;
  reg        tx_fifo_overflow_flag;
  reg        parity_error_flag;
  reg        framing_error_flag;
  reg        break_detect_flag;
  reg        address_byte_detect_flag;
  reg        clear_to_send_change_detect;
  reg        rx_timeout_flag;
  reg        tx_holding_empty_flag;
  reg        rx_data_available_flag;

  reg        cts_meta;
  reg        cts_sync;
  reg        cts_last;

  wire       buffer_error_flag;
  wire       rx_line_status_flag;
  wire       modem_change_flag;
  wire       cts_changed;
  wire [5:0] flags;
  wire [5:0] indicators;
  wire       wr_fifo_status;
  wire       wr_modem_status;
  wire       timeout_hit;
  wire [7:0] timeout_count_inc;
  wire [4:0] trig_level_ext;

  reg  [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Data port strobes

  // A read of the data port pops the receive FIFO; a write pushes transmit.
  // Both strobes are combinational so the FIFOs act in the same cycle as
  // the register access; a registered strobe would let a back-to-back
  // read see the old head byte.
  assign rx_read_strobe  = reg_rd && (reg_addr == `OFS_DATA_PORT);
  assign tx_write_strobe = reg_wr && (reg_addr == `OFS_DATA_PORT);

  // Write data held in a flop so the FIFO sees a stable byte
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_write_data <= 8'h00;
    end else if (tx_write_strobe) begin
      tx_write_data <= reg_wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Enables, trigger level, RS-485 mode and time-out compare value.
  // Writes to unmapped offsets and to the status word fall through the
  // default branch and change nothing; the status word is read-only.
  // A new trigger level takes effect at the next edge, so the data
  // available flag may move one cycle after the write.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable            <= `RST_IRQ_ENABLE;
      rx_fifo_trigger_level <= `RST_TRIG_LEVEL;
      rs485_mode            <= 1'b0;
      timeout_compare_value <= `RST_TIMEOUT_CMP;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_IRQ_ENABLE: begin
          irq_enable <= reg_wdata[8:0];
        end
        `OFS_FIFO_CTRL: begin
          rx_fifo_trigger_level <= reg_wdata[`FC_TRIG_MSB:`FC_TRIG_LSB];
          rs485_mode            <= reg_wdata[`FC_RS485];
        end
        `OFS_TIMEOUT: begin
          timeout_compare_value <= reg_wdata[`TO_CMP_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear-to-send synchroniser and change detect

  // Pin is asynchronous; the edge detector compares the second and third stages only.
  // All three stages reset high to match the idle level of the pin, so no
  // false change is flagged when reset is released with the pin idle.
  // A pin held low through reset is reported as a change a few edges later.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
      cts_last <= 1'b1;
    end else begin
      cts_meta <= clear_to_send_input_n;
      cts_sync <= cts_meta;
      cts_last <= cts_sync;
    end
  end

  assign cts_changed = cts_sync ^ cts_last;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky source flags, cleared by writing one

  assign wr_fifo_status  = reg_wr && (reg_addr == `OFS_FIFO_STATUS);
  assign wr_modem_status = reg_wr && (reg_addr == `OFS_MODEM_STATUS);

  // An event in the clearing cycle wins, so no overflow or error is lost.
  // Every flag clears only on a one in its own bit of the write, so
  // software can clear one source without racing the others.
  // The status word itself has no clear path: it only mirrors these flags.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_fifo_overflow_flag       <= 1'b0; // R23
      tx_fifo_overflow_flag       <= 1'b0;
      parity_error_flag           <= 1'b0;
      framing_error_flag          <= 1'b0;
      break_detect_flag           <= 1'b0;
      address_byte_detect_flag    <= 1'b0;
      clear_to_send_change_detect <= 1'b0;
    end else begin
      rx_fifo_overflow_flag <= rx_overflow_event |
        (rx_fifo_overflow_flag & ~(wr_fifo_status & reg_wdata[`FS_RX_OVF])); // R3
      tx_fifo_overflow_flag <= tx_overflow_event |
        (tx_fifo_overflow_flag & ~(wr_fifo_status & reg_wdata[`FS_TX_OVF])); // R3
      parity_error_flag <= parity_error_event |
        (parity_error_flag & ~(wr_fifo_status & reg_wdata[`FS_PARITY]));
      framing_error_flag <= framing_error_event |
        (framing_error_flag & ~(wr_fifo_status & reg_wdata[`FS_FRAMING]));
      break_detect_flag <= break_event |
        (break_detect_flag & ~(wr_fifo_status & reg_wdata[`FS_BREAK]));
      // Address bytes only count in RS-485 mode
      address_byte_detect_flag <= (rs485_mode & address_byte_event) | // R11
        (address_byte_detect_flag & ~(wr_fifo_status & reg_wdata[`FS_ADDR_DET]));
      clear_to_send_change_detect <= cts_changed | // R7
        (clear_to_send_change_detect & ~(wr_modem_status & reg_wdata[`MS_CTS_DET])); // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived read-only flags

  // Buffer error follows the two overflow flags and has no state of its own
  assign buffer_error_flag = rx_fifo_overflow_flag | tx_fifo_overflow_flag; // R1

  // Address detect only contributes in RS-485 mode, so a stale one is masked
  assign rx_line_status_flag = break_detect_flag | framing_error_flag | parity_error_flag | // R10 R12
                               (rs485_mode & address_byte_detect_flag); // R11 R13

  assign modem_change_flag = clear_to_send_change_detect; // R7 R9

  ////////////////////////////////////////////////////////////////////////////
  // Receive time-out counter

  // Counter stops at the compare value so the flag is raised only once.
  // A compare value of zero never fires: the counter already sits there.
  // The count is in baud periods, so the wait scales with the line rate;
  // a small compare value can fire while a character is still arriving.
  assign timeout_count_inc = timeout_count + 8'h01;
  assign timeout_hit = baud_tick && !rx_fifo_push && (rx_fifo_count != 5'h00) &&
                       (timeout_count != timeout_compare_value) &&
                       (timeout_count_inc == timeout_compare_value); // R4

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_count <= 8'h00;
    end else if (rx_fifo_push) begin
      timeout_count <= 8'h00; // R21
    end else if (baud_tick && (timeout_count != timeout_compare_value)) begin
      timeout_count <= timeout_count_inc; // R21
    end
  end

  // Cleared by a data read while receiving or by the FIFO running empty.
  // A hit in the same cycle as a clear wins, so a time-out is never lost.
  // A read with the receiver idle leaves the flag alone.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_timeout_flag <= 1'b0;
    end else if (timeout_hit) begin
      rx_timeout_flag <= 1'b1; // R4
    end else if ((rx_read_strobe && rx_active) || (rx_fifo_count == 5'h00)) begin
      rx_timeout_flag <= 1'b0; // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding empty

  // Set when the final word leaves for the shifter; set wins over a write.
  // The empty level is taken in the same cycle as the load pulse, so a
  // load that leaves words behind does not raise the flag.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_empty_flag <= 1'b0;
    end else if (tx_shift_load && tx_fifo_empty) begin
      tx_holding_empty_flag <= 1'b1; // R15
    end else if (tx_write_strobe) begin
      tx_holding_empty_flag <= 1'b0; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive data available

  assign trig_level_ext = {1'b0, rx_fifo_trigger_level};

  // Above the trigger level the flag holds its last value.
  // The level is a direct byte count; a level of zero keeps the flag set
  // for good, since the count can never drop below it.
  // The level is widened by one bit to compare against the five-bit count.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_available_flag <= 1'b0;
    end else if (rx_fifo_count == trig_level_ext) begin
      rx_data_available_flag <= 1'b1; // R18
    end else if (rx_fifo_count < trig_level_ext) begin
      rx_data_available_flag <= 1'b0; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt indicators

  assign flags = {buffer_error_flag, rx_timeout_flag, modem_change_flag,
                  rx_line_status_flag, tx_holding_empty_flag, rx_data_available_flag};

  // Each indicator is its flag gated by the matching enable.
  // The buffer error enable sits apart from the others in the enable word,
  // so it is gathered next to the low five enables here.
  // Indicators are combinational from flops, so they follow an enable
  // write in the cycle after it with no extra delay.
  assign indicators = flags & {irq_enable[`EN_BUFERR], irq_enable[`EN_TOUT:`EN_RDA]}; // R22

  assign rda_irq          = indicators[`ST_RDA];    // R20
  assign thre_irq         = indicators[`ST_THRE];   // R17
  assign rls_irq          = indicators[`ST_RLS];    // R14
  assign modem_irq        = indicators[`ST_MODEM];  // R8
  assign timeout_irq      = indicators[`ST_TOUT];   // R6
  assign buffer_error_irq = indicators[`ST_BUFERR]; // R2

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Read data are valid only in the cycle after the strobe, zero otherwise.
  // Unmapped offsets read as zero. The decode is combinational and the
  // result is registered below, which keeps the read data off any
  // combinational path to the bus.
  always @* begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      `OFS_DATA_PORT: begin
        next_rdata[7:0] = rx_fifo_data;
      end
      `OFS_IRQ_ENABLE: begin
        next_rdata[8:0] = irq_enable;
      end
      `OFS_IRQ_STATUS: begin
        next_rdata[5:0]  = flags;
        next_rdata[13:8] = indicators; // R22
      end
      `OFS_FIFO_STATUS: begin
        next_rdata[`FS_RX_OVF]   = rx_fifo_overflow_flag;
        next_rdata[`FS_ADDR_DET] = address_byte_detect_flag;
        next_rdata[`FS_PARITY]   = parity_error_flag;
        next_rdata[`FS_FRAMING]  = framing_error_flag;
        next_rdata[`FS_BREAK]    = break_detect_flag;
        next_rdata[`FS_TX_OVF]   = tx_fifo_overflow_flag;
      end
      `OFS_MODEM_STATUS: begin
        next_rdata[`MS_CTS_DET]   = clear_to_send_change_detect;
        next_rdata[`MS_CTS_STATE] = cts_sync;
      end
      `OFS_FIFO_CTRL: begin
        next_rdata[`FC_TRIG_MSB:`FC_TRIG_LSB] = rx_fifo_trigger_level;
        next_rdata[`FC_RS485]                 = rs485_mode;
      end
      `OFS_TIMEOUT: begin
        next_rdata[`TO_CMP_MSB:0] = timeout_compare_value;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // uart_irq_status

`default_nettype wire

// [bench/uart_irq_status_props.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_irq_props (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        rx_read_strobe,
  input wire logic        tx_write_strobe,
  input wire logic        rx_active,
  input wire logic        baud_tick,
  input wire logic [4:0]  rx_fifo_count,
  input wire logic        rx_overflow_event,
  input wire logic        tx_overflow_event,
  input wire logic        tx_shift_load,
  input wire logic        tx_fifo_empty,
  input wire logic        parity_error_event,
  input wire logic        modem_irq,
  input wire logic [7:0]  tx_write_data,
  input wire logic        rda_irq,
  input wire logic        thre_irq,
  input wire logic        rls_irq,
  input wire logic        timeout_irq,
  input wire logic        buffer_error_irq
);
  logic [8:0] en;
  logic [3:0] trig;
  // Shadow enables and trigger level, the indicators cannot be judged without them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en <= 9'h000;
      trig <= 4'h1;
    end else if (reg_wr && reg_addr == 8'h04) begin
      en <= reg_wdata[8:0];
    end else if (reg_wr && reg_addr == 8'h14) begin
      trig <= reg_wdata[7:4];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence ovf_ev;
    rx_overflow_event || tx_overflow_event;
  endsequence
  sequence ovf_clear;
    reg_wr && reg_addr == 8'h0c && reg_wdata[0] && reg_wdata[24];
  endsequence
  a_ovf_sets_berr: assert property (ovf_ev |=> buffer_error_irq == en[8])
    else $error("buffer error indicator wrong after overflow");
  a_berr_clear: assert property (ovf_clear ##0 !(rx_overflow_event || tx_overflow_event) |=> !buffer_error_irq)
    else $error("buffer error stayed after both overflows cleared");
  a_irq_gated: assert property (({buffer_error_irq, timeout_irq, rls_irq, thre_irq, rda_irq}
    & ~{en[8], en[4], en[2], en[1], en[0]}) == 5'h00) else $error("indicator set without enable");
  a_tmo_read_clr: assert property (rx_read_strobe && rx_active && !baud_tick |=> !timeout_irq)
    else $error("time-out stayed after data read");
  a_rls_set: assert property (parity_error_event |=> rls_irq == en[2])
    else $error("line status indicator wrong after parity error");
  a_thre_set: assert property (tx_shift_load && tx_fifo_empty |=> thre_irq == en[1])
    else $error("holding empty indicator wrong after last word");
  a_thre_clr: assert property (tx_write_strobe && !tx_shift_load |=> !thre_irq)
    else $error("holding empty stayed after data write");
  a_rda_level: assert property (rx_fifo_count == {1'b0, trig} |=> rda_irq == en[0])
    else $error("data available indicator wrong at trigger level");
  a_rda_low: assert property (rda_irq |-> $past(rx_fifo_count) >= {1'b0, $past(trig)})
    else $error("data available set below trigger level");
  a_modem_gated: assert property (modem_irq |-> en[3])
    else $error("modem indicator set without enable");
  a_txdata_held: assert property (tx_write_strobe |=> tx_write_data == $past(reg_wdata[7:0]))
    else $error("transmit byte not taken from data port write");
endmodule // uart_irq_props
bind uart_irq_status uart_irq_props chk_u (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .rx_read_strobe,
  .tx_write_strobe, .rx_active, .baud_tick, .rx_fifo_count, .rx_overflow_event, .tx_overflow_event,
  .tx_shift_load, .tx_fifo_empty, .parity_error_event, .rda_irq, .thre_irq, .rls_irq, .timeout_irq,
  .buffer_error_irq, .modem_irq, .tx_write_data);
`default_nettype wire

// [bench/uart_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_line_model (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        push_req,
  input wire logic [7:0]  push_byte,
  input wire logic        pop,
  output logic     [4:0]  rx_fifo_count,
  output logic     [7:0]  rx_fifo_data,
  output logic            rx_fifo_push,
  output logic            baud_tick
);
  logic [1:0] div;
  logic [7:0] head;
  // Receive FIFO front end; baud every fourth clock keeps time-outs short
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 2'h0;
      head <= 8'h00;
      rx_fifo_push <= 1'b0;
      rx_fifo_count <= 5'h00;
    end else begin
      div <= div + 2'h1;
      rx_fifo_push <= push_req;
      if (push_req) begin
        head <= push_byte;
      end
      rx_fifo_count <= rx_fifo_count + 5'(push_req) - 5'(pop && rx_fifo_count != 5'h00);
    end
  end
  assign baud_tick = div == 2'h3;
  // Empty FIFO has no head: inverse value so stale data cannot match
  assign rx_fifo_data = rx_fifo_count != 5'h00 ? head : ~head;
endmodule // uart_line_model
`default_nettype wire

// [bench/uart_irq_status_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_irq_status_tb;
  logic        ref_clk, rst_n, reg_wr, reg_rd, push_req, cts_n;
  logic        rd_d = 1'b0;
  logic        tx_empty;
  logic [7:0]  reg_addr, push_byte;
  logic [31:0] reg_wdata, lfsr;
  logic [6:0]  ev;
  logic [31:0] exp_q[$];
  wire  [31:0] reg_rdata;
  wire  [4:0]  rx_fifo_count;
  wire  [7:0]  rx_fifo_data;
  wire         rx_fifo_push, baud_tick, rx_read_strobe;
  int          errors, check_count;
  uart_irq_status dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_fifo_count(rx_fifo_count),
    .rx_fifo_data(rx_fifo_data), .rx_fifo_push(rx_fifo_push), .rx_active(1'b1), .rx_overflow_event(ev[4]),
    .parity_error_event(ev[0]), .framing_error_event(ev[1]), .break_event(ev[2]), .address_byte_event(ev[3]),
    .baud_tick(baud_tick), .tx_overflow_event(ev[5]), .tx_shift_load(ev[6]), .tx_fifo_empty(tx_empty),
    .clear_to_send_input_n(cts_n), .rx_read_strobe(rx_read_strobe), .tx_write_strobe(), .tx_write_data(),
    .rda_irq(), .thre_irq(), .rls_irq(), .modem_irq(), .timeout_irq(), .buffer_error_irq());
  uart_line_model line_u (.ref_clk(ref_clk), .rst_n(rst_n), .push_req(push_req), .push_byte(push_byte),
    .pop(rx_read_strobe), .rx_fifo_count(rx_fifo_count), .rx_fifo_data(rx_fifo_data),
    .rx_fifo_push(rx_fifo_push), .baud_tick(baud_tick));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Expected word is queued now, the monitor compares when data appears
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic pulse(input int b);
    @(posedge ref_clk);
    ev <= 7'h01 << b;
    @(posedge ref_clk);
    ev <= 7'h00;
  endtask
  task conclude;
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Read data is valid only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_d) begin
      check_count++;
      if (reg_rdata !== exp_q[0]) begin
        errors++;
        $display("CHECK FAILED reg_rdata expected %h seen %h", exp_q[0], reg_rdata);
      end
      void'(exp_q.pop_front());
    end
    rd_d <= reg_rd;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    conclude;
  end
  initial begin
    {reg_wr, reg_rd, push_req, ev, reg_addr, reg_wdata, push_byte} = '0;
    cts_n = 1'b1;
    tx_empty = 1'b0;
    rst_n = 1'b0;
    lfsr = 32'hb5a5af55;
    repeat (12) @(posedge ref_clk);
    #5 rst_n = 1'b1;
    rd(8'h04, 32'h0); rd(8'h08, 32'h0); rd(8'h14, 32'h10); rd(8'h20, 32'h0); rd(8'h3c, 32'h0);
    wr(8'h04, 32'h11f); rd(8'h04, 32'h11f);
    // Buffer error holds until both overflow flags are cleared
    pulse(5); pulse(4); rd(8'h08, 32'h2020);
    wr(8'h0c, 32'h1); rd(8'h08, 32'h2020); rd(8'h0c, 32'h1000000);
    wr(8'h0c, 32'h1000001); rd(8'h08, 32'h0);
    for (int i = 0; i < 3; i++) begin
      pulse(i); rd(8'h08, 32'h404);
      wr(8'h0c, 32'h10 << i); rd(8'h08, 32'h0);
    end
    // Address byte only counts once the rs485 mode is on
    pulse(3); rd(8'h08, 32'h0); wr(8'h14, 32'h110); pulse(3); rd(8'h08, 32'h404); rd(8'h0c, 32'h8);
    wr(8'h0c, 32'h8); rd(8'h08, 32'h0);
    @(posedge ref_clk) cts_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd(8'h08, 32'h808); wr(8'h10, 32'h1); rd(8'h08, 32'h0);
    // A load that leaves words behind must not raise holding empty
    pulse(6); rd(8'h08, 32'h0);
    @(posedge ref_clk) tx_empty <= 1'b1;
    pulse(6); rd(8'h08, 32'h202);
    lfsr = lfsr_next(lfsr);
    wr(8'h00, {24'h0, lfsr[7:0]}); rd(8'h08, 32'h0);
    // One random byte arrives, then the line goes quiet
    wr(8'h20, 32'h3);
    lfsr = lfsr_next(lfsr);
    @(posedge ref_clk);
    push_req <= 1'b1;
    push_byte <= lfsr[7:0];
    @(posedge ref_clk) push_req <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rd(8'h08, 32'h1111);
    rd(8'h00, {24'h0, lfsr[7:0]}); rd(8'h08, 32'h0);
    repeat (3) @(posedge ref_clk);
    conclude;
  end
endmodule // uart_irq_status_tb
`default_nettype wire
